// file: src/nsf_fifo.sv
// Purpose: small shift-register fifo between the framer and the byte sink
// Assumes: single clock, asynchronous active-high reset
// Notes:   head entry and all flags are flops so outputs need no logic
`timescale 1ns/1ps

module nsf_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("nsf_fifo: bad parameters");
        end
    end

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];
    logic [DEPTH-1:0] vld_q;
    logic [DEPTH-1:0] vld_shift;
    logic             pop;
    logic             push;

    assign pop       = vld_q[0] & out_ready;
    assign push      = in_valid & ~vld_q[DEPTH-1];
    assign vld_shift = pop ? (vld_q >> 1) : vld_q;
    assign in_ready  = ~vld_q[DEPTH-1];
    assign out_valid = vld_q[0];
    assign out_data  = mem_q[0];

    // a full fifo refuses a push even if it pops in the same cycle;
    // costs one bubble but keeps in_ready a plain flop
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vld_q <= '0;
        end else begin
            vld_q <= push ? (vld_shift | ~vld_shift
                             & {vld_shift[DEPTH-2:0], 1'b1})
                          : vld_shift;
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !vld_shift[i] &&
                (i == 0 || vld_shift[(i == 0) ? 0 : i-1])) begin
                mem_q[i] <= in_data;
            end else if (pop && i < DEPTH-1) begin
                mem_q[i] <= mem_q[(i < DEPTH-1) ? i+1 : i];
            end
        end
    end
endmodule : nsf_fifo

// file: src/nsf_formatter.sv
// Purpose: navigation state packet formatter with an Avalon-MM register file
// Assumes: 40 MHz clock, asynchronous active-high reset, software fills
//          field registers then writes a packet identifier to start a send
// Notes:   payload bytes leave least significant byte first, one per cycle
// Operation
// - full state packet id 20, 112 bytes, system then filter word
// - epoch seconds at 4, microseconds at 8, lat/lon/height fp64 12..28
// - velocity NED at 36..44, body accel 48..56, g-force at 60
// - roll, pitch, heading 64..72, angular rates 76..84
// - uncertainties 88..96, depth 100, seabed height 104, heave 108
// - every flag bit except filter bits 6..4 is boolean, set means true
// - system word bits 0..9 as listed, bits 3 and 8 reserved zero
// - system word bits 10..15 temperature, velocity, water, antenna, overflow
// - filter word init bits 0..3, events 7..8, enables/tracking 9..15
// - filter bits 6..4 carry the 3-bit satellite fix code 0..7
// - epoch seconds count UTC since 1970 without leap seconds
// - microseconds kept within 0 to 999999
// - seabed height trusted only while seabed tracking flag set
// - epoch time packet id 21, 8 bytes, seconds then microseconds
// - calendar packet id 22, 14 bytes, fields within documented ranges
// - flags-only packet id 23, 4 bytes, system then filter word
// - position uncertainty packet id 24, 12 bytes at 0, 4, 8
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

package nsf_pkg;
    localparam logic [7:0] ID_FULL   = 8'h14;
    localparam logic [7:0] ID_EPOCH  = 8'h15;
    localparam logic [7:0] ID_CAL    = 8'h16;
    localparam logic [7:0] ID_FLAGS  = 8'h17;
    localparam logic [7:0] ID_UNCERT = 8'h18;
    localparam logic [6:0] LEN_FULL   = 7'h70;
    localparam logic [6:0] LEN_EPOCH  = 7'h08;
    localparam logic [6:0] LEN_CAL    = 7'h0E;
    localparam logic [6:0] LEN_FLAGS  = 7'h04;
    localparam logic [6:0] LEN_UNCERT = 7'h0C;
    // word index inside the full record of the first field of the epoch and uncertainty packets, and of seabed height
    localparam logic [4:0] WIDX_EPOCH  = 5'h01;
    localparam logic [4:0] WIDX_UNCERT = 5'h16;
    localparam logic [4:0] WIDX_SEABED = 5'h1A;
    localparam int         WORDS_FULL  = 28;
    localparam int         WIDX_DATA0  = 3;
    // reserved system bits 3 and 8 read and send as zero
    localparam logic [15:0] SYS_MASK   = 16'hFEF7;
    localparam int          FIX_LSB    = 4;
    localparam int          FLT_SEABED = 11;
    localparam logic [31:0] USEC_MAX   = 32'h000F423F;
    localparam logic [15:0] YDAY_MAX   = 16'h016D;
    localparam logic [7:0]  MONTH_MAX  = 8'h0B;
    localparam logic [7:0]  MDAY_MIN   = 8'h01;
    localparam logic [7:0]  MDAY_MAX   = 8'h1F;
    localparam logic [7:0]  WDAY_MAX   = 8'h06;
    localparam logic [7:0]  HOUR_MAX   = 8'h17;
    localparam logic [7:0]  MINSEC_MAX = 8'h3B;
    // register byte addresses
    localparam logic [7:0] REG_SEND   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SYS    = 8'h08;
    localparam logic [7:0] REG_FILT   = 8'h0C;
    localparam logic [7:0] REG_SECS   = 8'h10;
    localparam logic [7:0] REG_USEC   = 8'h14;
    localparam logic [7:0] REG_DATE   = 8'h18;
    localparam logic [7:0] REG_CLOCKA = 8'h1C;
    localparam logic [7:0] REG_CLOCKB = 8'h20;
    localparam logic [7:0] REG_DATA   = 8'h80;
    localparam logic [7:0] REG_DATA_END = 8'hF0;
    localparam int ST_BUSY   = 0;
    localparam int ST_BADID  = 1;
    localparam int ST_RANGE  = 2;
    localparam int ST_SEABED = 3;
    typedef enum logic [2:0] {
        NSF_FIX_NONE = 3'h0,
        NSF_FIX_2D   = 3'h1,
        NSF_FIX_3D   = 3'h2,
        NSF_FIX_SBAS = 3'h3,
        NSF_FIX_DIFF = 3'h4,
        NSF_FIX_COMM = 3'h5,
        NSF_FIX_RTKF = 3'h6,
        NSF_FIX_RTKX = 3'h7
    } nsf_fix_e;
    typedef enum logic [0:0] {
        NSF_IDLE = 1'b0,
        NSF_SEND = 1'b1
    } nsf_state_e;
endpackage : nsf_pkg

module nsf_formatter #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic             st_valid,
    input  wire logic        st_ready,
    output logic [7:0]       st_data,
    output logic [7:0]       st_pkt_id,
    output logic             st_sop,
    output logic             st_eop
);
    initial begin
        if (FIFO_DEPTH < 2) begin
            $error("nsf_formatter: FIFO_DEPTH below 2");
        end
    end

    function automatic logic [31:0] apply_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : apply_be

    // least significant byte first, same for every packet
    function automatic logic [7:0] lane(input logic [31:0] w,
                                        input logic [1:0]  sel);
        return w[8*sel +: 8];
    endfunction : lane

    // registers
    logic [15:0]            sys_q;
    logic [15:0]            filt_q;
    nsf_pkg::nsf_fix_e      fix_q;
    logic [31:0]            secs_q;
    logic [31:0]            usec_q;
    logic [31:0]            date_q;
    logic [31:0]            clka_q;
    logic [15:0]            clkb_q;
    logic [31:0]            data_q [nsf_pkg::WIDX_DATA0:nsf_pkg::WORDS_FULL-1];
    logic                   badid_q;
    logic                   range_q;
    logic                   wait_q;
    logic [31:0]            rdata_q;
    nsf_pkg::nsf_state_e    state_q;
    logic [6:0]             idx_q;
    logic [6:0]             len_q;
    logic [7:0]             id_q;

    // bus decode
    wire        req      = avs_read | avs_write;
    // writes stall while a packet streams so its fields stay coherent
    wire        can_go   = avs_read | (state_q == nsf_pkg::NSF_IDLE);
    wire        wr       = avs_write & ~wait_q;
    wire [7:0]  addr     = avs_address;
    wire        in_data  = addr >= nsf_pkg::REG_DATA &&
                           addr <  nsf_pkg::REG_DATA_END &&
                           addr[1:0] == 2'b00;
    wire [4:0]  data_idx = 5'((addr - nsf_pkg::REG_DATA) >> 2);
    wire        data_wr  = wr & in_data &
                           (data_idx >= 5'(nsf_pkg::WIDX_DATA0));
    wire [7:0]  send_id  = avs_writedata[7:0];
    wire        send_wr  = wr & (addr == nsf_pkg::REG_SEND) &
                           avs_byteenable[0];
    wire        stat_wr  = wr & (addr == nsf_pkg::REG_STATUS) &
                           avs_byteenable[0];

    // record words as they go on the wire
    wire [15:0] sys_word  = sys_q &
                            nsf_pkg::SYS_MASK;
    wire [15:0] filt_word = {filt_q[15:7], fix_q,
                             filt_q[3:0]};
    wire [31:0] usec_out  = (usec_q > nsf_pkg::USEC_MAX) ?
                            nsf_pkg::USEC_MAX : usec_q;
    wire        seabed_ok = filt_word[nsf_pkg::FLT_SEABED];
    logic [31:0] full_w [0:nsf_pkg::WORDS_FULL-1];
    logic [31:0] cal_w  [0:3];

    assign full_w[0] = {filt_word, sys_word};
    assign full_w[1] = secs_q;
    assign full_w[2] = usec_out;
    // words 3..27: fp64 halves low word first, fp32 raw bits
    generate
        for (genvar g = nsf_pkg::WIDX_DATA0; g < nsf_pkg::WORDS_FULL;
             g++) begin : g_full
            assign full_w[g] = data_q[g];
        end
    endgenerate

    assign cal_w[0] = usec_out;
    assign cal_w[1] = date_q;
    assign cal_w[2] = clka_q;
    assign cal_w[3] = {16'h0000, clkb_q};

    wire [15:0] year_d  = date_q[15:0];
    wire [15:0] yday_d  = date_q[31:16];
    wire [7:0]  month_d = clka_q[7:0];
    wire [7:0]  mday_d  = clka_q[15:8];
    wire [7:0]  wday_d  = clka_q[23:16];
    wire [7:0]  hour_d  = clka_q[31:24];
    wire [7:0]  min_d   = clkb_q[7:0];
    wire [7:0]  sec_d   = clkb_q[15:8];
    wire        cal_ok  = yday_d  <= nsf_pkg::YDAY_MAX  &&
                          month_d <= nsf_pkg::MONTH_MAX &&
                          mday_d  >= nsf_pkg::MDAY_MIN  &&
                          mday_d  <= nsf_pkg::MDAY_MAX  &&
                          wday_d  <= nsf_pkg::WDAY_MAX  &&
                          hour_d  <= nsf_pkg::HOUR_MAX  &&
                          min_d   <= nsf_pkg::MINSEC_MAX &&
                          sec_d   <= nsf_pkg::MINSEC_MAX;

    // packet selection
    wire is_full   = send_id == nsf_pkg::ID_FULL;
    wire is_epoch  = send_id == nsf_pkg::ID_EPOCH;
    wire is_cal    = send_id == nsf_pkg::ID_CAL;
    wire is_flags  = send_id == nsf_pkg::ID_FLAGS;
    wire is_uncert = send_id == nsf_pkg::ID_UNCERT;
    wire id_known  = is_full | is_epoch | is_cal | is_flags | is_uncert;
    wire start     = send_wr & id_known & (~is_cal | cal_ok);
    wire [6:0] len_sel = is_full  ? nsf_pkg::LEN_FULL  :
                         is_epoch ? nsf_pkg::LEN_EPOCH :
                         is_cal   ? nsf_pkg::LEN_CAL   :
                         is_flags ? nsf_pkg::LEN_FLAGS :
                                    nsf_pkg::LEN_UNCERT;

    wire [4:0] widx = idx_q[6:2];
    wire [31:0] cur_word =
        (id_q == nsf_pkg::ID_EPOCH)  ?
            full_w[widx + nsf_pkg::WIDX_EPOCH] :
        (id_q == nsf_pkg::ID_CAL)    ? cal_w[widx[1:0]] :
        (id_q == nsf_pkg::ID_UNCERT) ?
            full_w[widx + nsf_pkg::WIDX_UNCERT] :
            full_w[widx];
    wire [7:0] cur_byte = lane(cur_word, idx_q[1:0]);

    // stream into the fifo
    logic fifo_in_ready;
    wire  sending = state_q == nsf_pkg::NSF_SEND;
    wire  push    = sending & fifo_in_ready;
    wire  last    = idx_q == len_q - 7'd1;

    nsf_fifo #(
        .WIDTH (18),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .in_valid  (sending),
        .in_ready  (fifo_in_ready),
        .in_data   ({id_q, idx_q == 7'd0, last, cur_byte}),
        .out_valid (st_valid),
        .out_ready (st_ready),
        .out_data  ({st_pkt_id, st_sop, st_eop, st_data})
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= nsf_pkg::NSF_IDLE;
            idx_q   <= 7'h00;
            len_q   <= 7'h00;
            id_q    <= 8'h00;
        end else if (start) begin
            state_q <= nsf_pkg::NSF_SEND;
            idx_q   <= 7'h00;
            len_q   <= len_sel;
            id_q    <= send_id;
        end else if (push) begin
            idx_q   <= idx_q + 7'd1;
            state_q <= last ? nsf_pkg::NSF_IDLE : nsf_pkg::NSF_SEND;
        end
    end

    // bus handshake: answer one cycle after the request, except a write while a packet streams
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q & can_go);
        end
    end

    // field registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_q  <= 16'h0000;
            filt_q <= 16'h0000;
            fix_q  <= nsf_pkg::NSF_FIX_NONE;
            secs_q <= 32'h00000000;
            usec_q <= 32'h00000000;
            date_q <= 32'h00000000;
            clka_q <= 32'h00000100;
            clkb_q <= 16'h0000;
        end else if (wr) begin
            case (addr)
                nsf_pkg::REG_SYS: begin
                    sys_q <= 16'(apply_be({16'h0000, sys_q}, avs_writedata,
                                          avs_byteenable));
                end
                nsf_pkg::REG_FILT: begin
                    filt_q <= 16'(apply_be({16'h0000, filt_q},
                                           avs_writedata, avs_byteenable));
                    if (avs_byteenable[0]) begin
                        fix_q <= nsf_pkg::nsf_fix_e'(
                            avs_writedata[nsf_pkg::FIX_LSB +: 3]);
                    end
                end
                nsf_pkg::REG_SECS: begin
                    secs_q <= apply_be(secs_q, avs_writedata, avs_byteenable);
                end
                nsf_pkg::REG_USEC: begin
                    usec_q <= apply_be(usec_q, avs_writedata, avs_byteenable);
                end
                nsf_pkg::REG_DATE: begin
                    date_q <= apply_be(date_q, avs_writedata, avs_byteenable);
                end
                nsf_pkg::REG_CLOCKA: begin
                    clka_q <= apply_be(clka_q, avs_writedata, avs_byteenable);
                end
                nsf_pkg::REG_CLOCKB: begin
                    clkb_q <= 16'(apply_be({16'h0000, clkb_q}, avs_writedata,
                                           avs_byteenable));
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (data_wr) begin
            data_q[data_idx] <= apply_be(data_q[data_idx], avs_writedata,
                                         avs_byteenable);
        end
    end

    // refused sends leave sticky flags, write one to clear; a new refusal
    // in the clearing cycle wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            badid_q <= 1'b0;
            range_q <= 1'b0;
        end else begin
            badid_q <= (send_wr & ~id_known) |
                       (badid_q & ~(stat_wr & avs_writedata[nsf_pkg::ST_BADID]));
            range_q <= (send_wr & is_cal & ~cal_ok) |
                       (range_q & ~(stat_wr & avs_writedata[nsf_pkg::ST_RANGE]));
        end
    end

    // read data
    logic [31:0] rd_mux;
    assign rd_mux =
        (addr == nsf_pkg::REG_SEND)   ? {24'h000000, id_q} :
        (addr == nsf_pkg::REG_STATUS) ? {28'h0000000, seabed_ok, range_q,
                                         badid_q, sending} :
        (addr == nsf_pkg::REG_SYS)    ? {16'h0000, sys_word} :
        (addr == nsf_pkg::REG_FILT)   ? {16'h0000, filt_word} :
        (addr == nsf_pkg::REG_SECS)   ? secs_q :
        (addr == nsf_pkg::REG_USEC)   ? usec_out :
        (addr == nsf_pkg::REG_DATE)   ? date_q :
        (addr == nsf_pkg::REG_CLOCKA) ? clka_q :
        (addr == nsf_pkg::REG_CLOCKB) ? {16'h0000, clkb_q} :
        in_data                       ? full_w[data_idx] :
                                        32'h00000000;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
        end else if (req & wait_q & can_go) begin
            rdata_q <= rd_mux;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
endmodule : nsf_formatter

// file: testbench/nsf_formatter_asserts.sv
// Purpose: port checks on the packet formatter
// Assumes: one clock, rst asynchronous and active high
// Notes:   byte count rebuilt from the stream handshake
`timescale 1ns/1ps

module nsf_formatter_asserts (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        st_valid,
    input wire logic        st_ready,
    input wire logic [7:0]  st_data,
    input wire logic [7:0]  st_pkt_id,
    input wire logic        st_sop,
    input wire logic        st_eop
);
    logic [6:0] cnt_q;
    logic [7:0] id_q;
    wire        take = st_valid && st_ready;
    wire [7:0]  cal_max = cnt_q == 7'h07 ? 8'h01 : cnt_q == 7'h08 ? 8'h0B :
        cnt_q == 7'h09 ? 8'h1F : cnt_q == 7'h0A ? 8'h06 :
        cnt_q == 7'h0B ? 8'h17 : 8'h3B;
    wire        usec_hi = (st_pkt_id == 8'h14 && cnt_q == 7'h0B) ||
        (st_pkt_id == 8'h15 && cnt_q == 7'h07) ||
        (st_pkt_id == 8'h16 && cnt_q == 7'h03);
    wire [6:0]  plen = st_pkt_id == 8'h14 ? 7'h70 :
        st_pkt_id == 8'h15 ? 7'h08 : st_pkt_id == 8'h16 ? 7'h0E :
        st_pkt_id == 8'h17 ? 7'h04 : 7'h0C;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q <= 7'h00;
            id_q  <= 8'h00;
        end else if (take) begin
            cnt_q <= st_eop ? 7'h00 : cnt_q + 7'h01;
            id_q  <= st_sop ? st_pkt_id : id_q;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence s_stall; st_valid && !st_ready; endsequence
    sequence s_rd_req; avs_read && avs_waitrequest; endsequence
    sequence s_one_wait; !avs_waitrequest ##1 avs_waitrequest; endsequence

    AST_PKT_LEN: assert property (
        st_valid && st_eop |-> cnt_q + 7'h01 == plen)
        else $error("packet length does not match its id");
    AST_SOP_ID: assert property (
        st_valid && st_sop |-> cnt_q == 7'h00 &&
        st_pkt_id inside {[8'h14:8'h18]})
        else $error("first byte misplaced or unknown id");
    AST_MID_ID: assert property (
        st_valid && !st_sop |-> cnt_q != 7'h00 && st_pkt_id == id_q)
        else $error("id changed inside a packet");
    AST_RSVD_SYS: assert property (
        st_valid && (st_pkt_id == 8'h14 || st_pkt_id == 8'h17) &&
        cnt_q < 7'h02 |-> !(cnt_q[0] ? st_data[0] : st_data[3]))
        else $error("reserved system bit sent as one");
    AST_USEC_MAX: assert property (
        st_valid && usec_hi |-> st_data <= 8'h0F)
        else $error("microseconds above range");
    AST_CAL_RANGE: assert property (
        st_valid && st_pkt_id == 8'h16 && cnt_q >= 7'h07 |->
        st_data <= cal_max && !(cnt_q == 7'h09 && st_data == 8'h00))
        else $error("calendar field out of range");
    AST_HOLD: assert property (s_stall |=> st_valid &&
        $stable(st_data) && $stable(st_pkt_id) && $stable(st_eop))
        else $error("stalled byte changed");
    AST_RD_ONE: assert property (s_rd_req |=> s_one_wait)
        else $error("read answer not one cycle");
    AST_WR_ANS: assert property (
        avs_write && avs_waitrequest |-> ##[1:400] !avs_waitrequest)
        else $error("write never answered");
endmodule : nsf_formatter_asserts

bind nsf_formatter nsf_formatter_asserts u_nsf_formatter_asserts (.*);

// file: testbench/nsf_sink.sv
// Purpose: host byte sink, one packet at a time
// Assumes: rnd makes ready random, hold stalls fully
// Notes:   last packet stays in buf_q
`timescale 1ns/1ps

module nsf_sink (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       hold,
    input wire logic       rnd,
    input wire logic       st_valid,
    output logic           st_ready,
    input wire logic [7:0] st_data,
    input wire logic [7:0] st_pkt_id,
    input wire logic       st_sop,
    input wire logic       st_eop
);
    logic [7:0] buf_q [0:127];
    logic [7:0] id_q;
    logic       alt_ok_q;
    int         idx_q;
    int         len_q;
    int         pkts_q;

    always @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ready <= 1'b0;
            alt_ok_q <= 1'b0;
            idx_q    <= 0;
            pkts_q   <= 0;
        end else begin
            st_ready <= !hold && (!rnd || $urandom_range(1) == 1);
            if (st_valid && st_ready) begin
                buf_q[st_sop ? 0 : idx_q] <= st_data;
                idx_q <= st_sop ? 1 : idx_q + 1;
                if (st_pkt_id == 8'h14 && idx_q == 3 && !st_sop) begin
                    alt_ok_q <= st_data[3];
                end
                if (st_eop) begin
                    len_q  <= st_sop ? 1 : idx_q + 1;
                    id_q   <= st_pkt_id;
                    pkts_q <= pkts_q + 1;
                end
            end
        end
    end
endmodule : nsf_sink

// file: testbench/test_nsf_formatter.sv
// Purpose: self-checking bench for the packet formatter
// Assumes: bus tasks start just after a rising edge
// Notes:   w and cal hold expected payload
`timescale 1ns/1ps

module test_nsf_formatter;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata, rdw;
    logic        avs_waitrequest, st_valid, st_ready, st_sop, st_eop;
    logic [7:0]  st_data, st_pkt_id;
    logic        hold = 1'b0;
    logic        rnd = 1'b0;
    logic [15:0] sy, fl;
    logic [31:0] w [0:27];
    logic [31:0] cal [0:3];
    logic [31:0] us [4] = '{32'h0, 32'h000F423F, 32'h000F4240, 32'hFFFFFFFF};
    int          bad_count = 0;
    int          n_compared = 0;
    int          cycles = 0;

    nsf_formatter #(.FIFO_DEPTH(4)) u_nsf_formatter (.clock, .rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .st_valid,
        .st_ready, .st_data, .st_pkt_id, .st_sop, .st_eop);
    nsf_sink u_nsf_sink (.clock, .rst, .hold, .rnd, .st_valid, .st_ready,
        .st_data, .st_pkt_id, .st_sop, .st_eop);

    initial begin
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk32(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk32

    task automatic chk8(input string nm, input logic [7:0] e, g);
        chk32(nm, {24'h0, e}, {24'h0, g});
    endtask : chk8

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clock);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rdw = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus_rd

    function automatic logic [31:0] clampu(input logic [31:0] u);
        return u > 32'h000F423F ? 32'h000F423F : u;
    endfunction : clampu

    function automatic int exp_len(input logic [7:0] id);
        return id == 8'h14 ? 112 : id == 8'h15 ? 8 : id == 8'h16 ? 14 :
            id == 8'h17 ? 4 : 12;
    endfunction : exp_len

    function automatic logic [7:0] exp_byte(input logic [7:0] id, int k);
        logic [31:0] v;
        v = id == 8'h16 ? cal[k/4] :
            w[(id == 8'h15 ? 1 : id == 8'h18 ? 22 : 0) + k/4];
        return v[8*(k%4) +: 8];
    endfunction : exp_byte

    task automatic send_check(input logic [7:0] id);
        int n0;
        n0 = u_nsf_sink.pkts_q;
        bus_wr(8'h00, {24'h0, id});
        while (u_nsf_sink.pkts_q == n0) @(posedge clock);
        chk8("packet id", id, u_nsf_sink.id_q);
        chk32("packet length", exp_len(id), u_nsf_sink.len_q);
        for (int k = 0; k < exp_len(id); k++)
            chk8("payload byte", exp_byte(id, k), u_nsf_sink.buf_q[k]);
    endtask : send_check

    task automatic set_flags(input logic [15:0] s, f);
        bus_wr(8'h08, {16'h0, s});
        bus_wr(8'h0C, {16'h0, f});
        w[0] = {f, s & 16'hFEF7};
        bus_rd(8'h08);
        chk32("system flags", {16'h0, s & 16'hFEF7}, rdw);
    endtask : set_flags

    task automatic set_time(input logic [31:0] s, u);
        bus_wr(8'h10, s);
        bus_wr(8'h14, u);
        w[1] = s;
        w[2] = clampu(u);
        cal[0] = w[2];
        bus_rd(8'h14);
        chk32("microseconds", w[2], rdw);
    endtask : set_time

    initial begin
        rdw = $urandom(32'hD135DF7E);
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus_rd(8'h1C);
        chk32("calendar reset", 32'h00000100, rdw);
        bus_rd(8'h40);
        chk32("unmapped read", 32'h00000000, rdw);
        $display("test reset done");
        rnd <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            sy = f == 0 ? 16'hFFFF : 16'($urandom);
            fl = 16'($urandom);
            fl[6:4] = 3'(f);
            set_flags(sy, fl);
            send_check(8'h17);
        end
        $display("test flags done");
        for (int i = 0; i < 4; i++) begin
            set_time($urandom, us[i]);
            send_check(8'h15);
        end
        $display("test epoch done");
        for (int i = 3; i < 28; i++) begin
            w[i] = $urandom;
            bus_wr(8'h80 + 8'(4 * i), w[i]);
        end
        send_check(8'h18);
        fl[11] = 1'b1;
        set_flags(16'($urandom), fl);
        hold <= 1'b1;
        fork
            begin
                repeat (40) @(posedge clock);
                hold <= 1'b0;
            end
        join_none
        send_check(8'h14);
        chk8("seabed trust", 8'h01, {7'h0, u_nsf_sink.alt_ok_q});
        $display("test full state done");
        cal[1] = {16'h016D, 16'($urandom)};
        cal[2] = 32'h17061F0B;
        cal[3] = 32'h00003B3B;
        bus_wr(8'h18, cal[1]);
        bus_wr(8'h1C, cal[2]);
        bus_wr(8'h20, cal[3]);
        send_check(8'h16);
        bus_wr(8'h1C, 32'h17061F0C);
        bus_wr(8'h00, 32'h00000016);
        bus_wr(8'h00, 32'h00000019);
        repeat (8) @(posedge clock);
        bus_rd(8'h04);
        chk32("refusal status", 32'h0000000E, rdw & 32'h0000000F);
        bus_wr(8'h04, 32'h00000006);
        bus_rd(8'h04);
        chk32("cleared status", 32'h00000008, rdw & 32'h0000000F);
        chk32("packets sent", 32'd15, 32'(u_nsf_sink.pkts_q));
        $display("test calendar done");
        end_of_test();
    end
endmodule : test_nsf_formatter
